/* trig_pkg.sv */
// Constants, types and helpers for the analyzer trigger sequencer.
// Function
// RULE1: One to four levels, count, match, without.
// RULE2: Wait at level until met, then advance.
// RULE3: Count above one needs that many matches.
// RULE4: Without match restarts at first level.
// RULE5: Total of level counts never above 13.
// RULE6: Single count above 13 clamps to 13.
// RULE7: Total above 13 refuses commit, three beeps.
// RULE8: One toggle switches field between OR, AND.
// RULE9: Word cycles true, inverted, excluded.
// RULE10: Cleared field is disabled, never matches.
// RULE11: Disabled single level never triggers.
// RULE12: Leave to predefined selects default sequence.
// RULE13: Stop storing after programmed qualified clocks.
// RULE14: Start offset sets delay from record depth.
// RULE15: Delay counts only doubly qualified clocks.
// RULE16: Far side gives 17 clocks after trigger.
// RULE17: Stop command needs only two more clocks.
// RULE18: Only post-trigger samples are guaranteed.
// RULE19: Delay quantised by channel width mode.
// RULE20: Zero delay stops storage at trigger.
// RULE21: Without match wins over advancing.
package trig_pkg;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [7:0] A_CTRL = 8'h00;
  localparam logic [7:0] A_CMD = 8'h04;
  localparam logic [7:0] A_KEY = 8'h08;
  localparam logic [7:0] A_COUNT = 8'h0C;
  localparam logic [7:0] A_DELAY = 8'h10;
  localparam logic [7:0] A_START = 8'h14;
  localparam logic [7:0] A_STATUS = 8'h18;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int C_START = 0;
  localparam int C_STOP = 1;
  localparam int C_ADD = 2;
  localparam int C_REM = 3;
  localparam int C_COMMIT = 4;
  localparam int C_PREDEF = 5;
  localparam int K_WORD = 0;
  localparam int K_FIELD = 2;
  localparam int K_LEVEL = 3;
  localparam int K_ACT = 5;
  localparam int CNT_LEVEL = 8;
  localparam int START_BEFORE = 16;
  localparam int ST_STATE = 0;
  localparam int ST_LEVEL = 2;
  localparam int ST_TOTAL = 4;
  localparam int ST_USER = 10;
  localparam int ST_DONE = 11;
  localparam int ST_NLEV = 12;

  // ----------------------------------------------------------------
  // Values, reset values and counts
  // ----------------------------------------------------------------
  localparam logic [1:0] ACT_WORD = 2'h0;
  localparam logic [1:0] ACT_OP = 2'h1;
  localparam logic [1:0] ACT_CLEAR = 2'h2;
  localparam logic [6:0] CNT_MAX = 7'h0D;
  localparam logic [5:0] TOTAL_MAX = 6'h0D;
  localparam logic [15:0] REC_DEPTH = 16'h03E7;
  localparam logic [15:0] FLUSH_TRIG = 16'h0011;
  localparam logic [15:0] FLUSH_STOP = 16'h0002;
  localparam logic [7:0] BEEP_CYC = 8'h0F;
  localparam logic [2:0] BEEP_PHASES = 3'h6;
  localparam logic [7:0] DEF_MATCH = 8'h01;
  localparam logic [7:0] DEF_WITHOUT = 8'h00;
  localparam logic [1:0] WIDTH_RST = 2'h3;
  localparam logic [2:0] NLEV_RST = 3'h1;
  localparam logic [6:0] CNT_RST = 7'h01;
  localparam logic [15:0] DELAY_RST = 16'h0000;

  // ----------------------------------------------------------------
  // Types and helpers
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {W_OFF = 2'b00, W_TRUE = 2'b01, W_INV = 2'b10} wstate_t;
  typedef enum logic [1:0] {
    S_IDLE = 2'b00, S_SEARCH = 2'b01, S_DELAY = 2'b10, S_FLUSH = 2'b11
  } run_t;

  // Next state of a word on a repeated key press.
  function automatic logic [1:0] word_next(input logic [1:0] s);
    if (s == W_OFF) begin
      return W_TRUE;
    end else if (s == W_TRUE) begin
      return W_INV;
    end
    return W_OFF;
  endfunction

  // Round a delay down to the step of the channel width mode.
  function automatic logic [15:0] quant(input logic [15:0] v, input logic [1:0] w);
    logic [15:0] q;
    q = (w == 2'h0) ? 16'h0028 : (w == 2'h1) ? 16'h0014 : (w == 2'h2) ? 16'h000A : 16'h0005;
    return v - (v % q);
  endfunction

endpackage

/* comb_eval.sv */
// Evaluator for one trigger word combination field.
`timescale 1ns/1ps
module comb_eval (
  input wire logic [7:0] i_words,
  input wire logic i_and,
  input wire logic [3:0] i_hit,
  output logic o_match
);
  logic any_in;
  logic all_t;
  logic one_t;
  logic term;

  // A field with no included word is disabled and never matches.
  always_comb begin
    any_in = 1'b0;
    all_t = 1'b1;
    one_t = 1'b0;
    term = 1'b0;
    for (int i = 0; i < 4; i++) begin
      term = (i_words[2*i +: 2] == trig_pkg::W_INV) ? ~i_hit[i] : i_hit[i];
      if (i_words[2*i +: 2] != trig_pkg::W_OFF) begin
        any_in = 1'b1;
        all_t = all_t & term;
        one_t = one_t | term;
      end
    end
    // RULE10: empty never matches.
    o_match = any_in & (i_and ? all_t : one_t);
  end
endmodule

/* tick_counter.sv */
// Down counter that pulses on the tick that completes a loaded length.
`timescale 1ns/1ps
module tick_counter (
  input wire logic i_mclk,
  input wire logic i_resetn,
  input wire logic i_load,
  input wire logic i_clr,
  input wire logic [15:0] i_len,
  input wire logic i_tick,
  output logic o_done
);
  logic [15:0] cnt;
  logic [15:0] next_cnt;

  // The pulse falls on the last tick itself, so no idle cycle follows it.
  assign o_done = i_tick && (cnt == 16'h0001);

  always_comb begin
    next_cnt = cnt;
    if (i_clr) begin
      next_cnt = 16'h0000;
    end else if (i_load) begin
      next_cnt = i_len;
    end else if (i_tick && cnt != 16'h0000) begin
      next_cnt = cnt - 16'h0001;
    end
  end

  always_ff @(posedge i_mclk or negedge i_resetn) begin
    if (!i_resetn) begin
      cnt <= 16'h0000;
    end else begin
      cnt <= next_cnt;
    end
  end
endmodule

/* trig_sequencer.sv */
// Trigger sequencer top: register port, level stepping and stop control.
`timescale 1ns/1ps
module trig_sequencer (
  input wire logic i_mclk,
  input wire logic i_resetn,
  input wire logic [7:0] i_addr,
  input wire logic [31:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [31:0] o_rdata,
  input wire logic i_sample_en,
  input wire logic i_data_qual,
  input wire logic [3:0] i_word_hit,
  output logic o_store,
  output logic o_trigger,
  output logic o_done,
  output logic o_beep,
  output logic [1:0] o_level
);
  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  logic [1:0] width, next_width;
  logic [2:0] nlev, next_nlev;
  logic [6:0] cnt [0:3];
  logic [6:0] next_cnt [0:3];
  logic [7:0] wst [0:3][0:1];
  logic [7:0] next_wst [0:3][0:1];
  logic op [0:3][0:1];
  logic next_op [0:3][0:1];
  logic [15:0] delay, next_delay;
  logic use_user, next_use_user;
  logic refuse;
  logic [5:0] total;
  trig_pkg::run_t st, next_st;
  logic [1:0] next_level;
  logic [3:0] rep, next_rep;
  logic next_store, next_trigger, next_done, next_beep;
  logic [2:0] bph, next_bph;
  logic [7:0] btm, next_btm;
  logic [31:0] next_rdata;
  logic q, use_eff, m_hit, w_hit, rep_met, fire;
  logic [1:0] a_last;
  logic [6:0] a_cnt;
  logic [7:0] a_mw, a_ww;
  logic a_mo, a_wo;
  logic cmd_wr, start_cmd, stop_cmd;
  logic dly_load, dly_done, fl_load, fl_done, fl_clr;
  logic [15:0] fl_len, st_val;
  logic [1:0] kl, cl;

  assign q = i_sample_en & i_data_qual;
  assign cmd_wr = i_wr && (i_addr == trig_pkg::A_CMD);
  assign start_cmd = cmd_wr && i_wdata[trig_pkg::C_START];
  assign stop_cmd = cmd_wr && i_wdata[trig_pkg::C_STOP];
  assign kl = i_wdata[trig_pkg::K_LEVEL +: 2];
  assign cl = i_wdata[trig_pkg::CNT_LEVEL +: 2];

  // ----------------------------------------------------------------
  // Active sequence selection
  // ----------------------------------------------------------------
  // User sequences exist only in the 16- and 32-channel modes.
  // RULE12: default sequence fallback.
  assign use_eff = use_user & width[1];
  assign a_last = use_eff ? 2'(nlev - 3'h1) : 2'h0;
  assign a_cnt = use_eff ? cnt[o_level] : trig_pkg::CNT_RST;
  assign a_mw = use_eff ? wst[o_level][0] : trig_pkg::DEF_MATCH;
  assign a_ww = use_eff ? wst[o_level][1] : trig_pkg::DEF_WITHOUT;
  assign a_mo = use_eff & op[o_level][0];
  assign a_wo = use_eff & op[o_level][1];

  comb_eval u_match (
    .i_words(a_mw),
    .i_and(a_mo),
    .i_hit(i_word_hit),
    .o_match(m_hit)
  );

  comb_eval u_without (
    .i_words(a_ww),
    .i_and(a_wo),
    .i_hit(i_word_hit),
    .o_match(w_hit)
  );

  // RULE3: repeat count reached.
  assign rep_met = (7'(rep) + 7'h01) >= a_cnt;
  // RULE11: disabled fields never fire.
  // RULE21: without blocks the final step.
  assign fire = (st == trig_pkg::S_SEARCH) && q && !w_hit && m_hit && rep_met
    && (o_level == a_last);

  // Total of the counts over the configured levels only.
  // RULE5: bounded total count.
  always_comb begin
    total = 6'h00;
    for (int i = 0; i < 4; i++) begin
      if (3'(i) < nlev) begin
        total = total + 6'(cnt[i]);
      end
    end
  end

  // A start offset before the trigger shortens the delay, after lengthens it.
  // RULE14: stop minus start is depth.
  assign st_val = i_wdata[trig_pkg::START_BEFORE]
    ? ((i_wdata[15:0] < trig_pkg::REC_DEPTH) ? trig_pkg::REC_DEPTH - i_wdata[15:0] : 16'h0000)
    : trig_pkg::REC_DEPTH + i_wdata[15:0];

  // ----------------------------------------------------------------
  // Configuration registers
  // ----------------------------------------------------------------
  // Setup edits; user settings survive a return to the default sequence.
  always_comb begin
    next_width = width;
    next_nlev = nlev;
    next_cnt = cnt;
    next_wst = wst;
    next_op = op;
    next_delay = delay;
    next_use_user = use_user;
    refuse = 1'b0;
    if (i_wr) begin
      if (i_addr == trig_pkg::A_CTRL) begin
        next_width = i_wdata[1:0];
      end else if (i_addr == trig_pkg::A_CMD) begin
        // RULE1: one to four levels.
        if (i_wdata[trig_pkg::C_ADD] && nlev < 3'h4) begin
          next_nlev = nlev + 3'h1;
        end else if (i_wdata[trig_pkg::C_REM] && nlev > 3'h1) begin
          next_nlev = nlev - 3'h1;
        end
        // RULE7: refuse an oversized total.
        if (i_wdata[trig_pkg::C_COMMIT]) begin
          if (total > trig_pkg::TOTAL_MAX) begin
            refuse = 1'b1;
          end else begin
            next_use_user = 1'b1;
          end
        end
        // RULE12: back to default sequence.
        if (i_wdata[trig_pkg::C_PREDEF]) begin
          next_use_user = 1'b0;
        end
      end else if (i_addr == trig_pkg::A_KEY) begin
        case (i_wdata[trig_pkg::K_ACT +: 2])
          trig_pkg::ACT_WORD: begin
            // RULE9: cycle word state.
            next_wst[kl][i_wdata[trig_pkg::K_FIELD]][2*i_wdata[1:0] +: 2] =
              trig_pkg::word_next(wst[kl][i_wdata[trig_pkg::K_FIELD]][2*i_wdata[1:0] +: 2]);
          end
          trig_pkg::ACT_OP: begin
            // RULE8: toggle whole field operator.
            next_op[kl][i_wdata[trig_pkg::K_FIELD]] = !op[kl][i_wdata[trig_pkg::K_FIELD]];
          end
          trig_pkg::ACT_CLEAR: begin
            // RULE10: clear disables field.
            next_wst[kl][i_wdata[trig_pkg::K_FIELD]] = 8'h00;
          end
          default: begin
            next_op = op;
          end
        endcase
      end else if (i_addr == trig_pkg::A_COUNT) begin
        // RULE6: clamp count entry.
        if (i_wdata[6:0] > trig_pkg::CNT_MAX) begin
          next_cnt[cl] = trig_pkg::CNT_MAX;
        end else begin
          next_cnt[cl] = i_wdata[6:0];
        end
      end else if (i_addr == trig_pkg::A_DELAY) begin
        // RULE19: quantise delay.
        next_delay = trig_pkg::quant(i_wdata[15:0], width);
      end else if (i_addr == trig_pkg::A_START) begin
        next_delay = trig_pkg::quant(st_val, width);
      end
    end
  end

  always_ff @(posedge i_mclk or negedge i_resetn) begin
    if (!i_resetn) begin
      width <= trig_pkg::WIDTH_RST;
      nlev <= trig_pkg::NLEV_RST;
      delay <= trig_pkg::DELAY_RST;
      use_user <= 1'b0;
      for (int i = 0; i < 4; i++) begin
        cnt[i] <= trig_pkg::CNT_RST;
        for (int j = 0; j < 2; j++) begin
          wst[i][j] <= 8'h00;
          op[i][j] <= 1'b0;
        end
      end
    end else begin
      width <= next_width;
      nlev <= next_nlev;
      delay <= next_delay;
      use_user <= next_use_user;
      cnt <= next_cnt;
      wst <= next_wst;
      op <= next_op;
    end
  end

  // ----------------------------------------------------------------
  // Post-trigger delay and capture flush counters
  // ----------------------------------------------------------------
  // RULE15: ticks only on qualified clocks.
  tick_counter u_delay (
    .i_mclk(i_mclk),
    .i_resetn(i_resetn),
    .i_load(dly_load),
    .i_clr(1'b0),
    .i_len(delay),
    .i_tick(q && st == trig_pkg::S_DELAY),
    .o_done(dly_done)
  );

  // The flush counts every external clock, qualified or not.
  tick_counter u_flush (
    .i_mclk(i_mclk),
    .i_resetn(i_resetn),
    .i_load(fl_load),
    .i_clr(fl_clr),
    .i_len(fl_len),
    .i_tick(i_sample_en && st == trig_pkg::S_FLUSH),
    .o_done(fl_done)
  );

  // ----------------------------------------------------------------
  // Sequencer, beeper and read port
  // ----------------------------------------------------------------
  // Pre-trigger depth is whatever was stored before the trigger; only the
  // post-trigger delay is enforced here.
  // RULE18: post-trigger count only.
  always_comb begin
    next_st = st;
    next_level = o_level;
    next_rep = rep;
    next_store = o_store;
    next_trigger = 1'b0;
    next_done = o_done;
    dly_load = 1'b0;
    fl_load = 1'b0;
    fl_clr = 1'b0;
    fl_len = trig_pkg::FLUSH_TRIG;
    case (st)
      trig_pkg::S_IDLE: begin
        if (start_cmd) begin
          next_st = trig_pkg::S_SEARCH;
          next_level = 2'h0;
          next_rep = 4'h0;
          next_store = 1'b1;
          next_done = 1'b0;
          fl_clr = 1'b1;
        end
      end
      trig_pkg::S_SEARCH: begin
        if (stop_cmd) begin
          // RULE17: stop needs two clocks.
          next_st = trig_pkg::S_FLUSH;
          next_store = 1'b0;
          fl_load = 1'b1;
          fl_len = trig_pkg::FLUSH_STOP;
        end else if (q && w_hit) begin
          // RULE4: restart from the first level.
          next_level = 2'h0;
          next_rep = 4'h0;
        end else if (fire) begin
          // RULE2: final level sets the trigger.
          next_trigger = 1'b1;
          if (delay == 16'h0000) begin
            // RULE20: zero delay stops at once.
            next_st = trig_pkg::S_FLUSH;
            next_store = 1'b0;
            fl_load = 1'b1;
          end else begin
            // RULE13: run the post-trigger delay.
            next_st = trig_pkg::S_DELAY;
            dly_load = 1'b1;
          end
        end else if (q && m_hit) begin
          // RULE3: count matches before advancing.
          if (rep_met) begin
            next_level = o_level + 2'h1;
            next_rep = 4'h0;
          end else begin
            next_rep = rep + 4'h1;
          end
        end
      end
      trig_pkg::S_DELAY: begin
        if (stop_cmd) begin
          next_st = trig_pkg::S_FLUSH;
          next_store = 1'b0;
          fl_load = 1'b1;
          fl_len = trig_pkg::FLUSH_STOP;
        end else if (dly_done) begin
          // RULE16: wait 17 clocks after stopping.
          next_st = trig_pkg::S_FLUSH;
          next_store = 1'b0;
          fl_load = 1'b1;
        end
      end
      default: begin
        if (fl_done) begin
          next_st = trig_pkg::S_IDLE;
          next_done = 1'b1;
        end
      end
    endcase
  end

  // Three beeps: odd phases sound, even phases are the gaps.
  always_comb begin
    next_bph = bph;
    next_btm = btm;
    if (refuse) begin
      next_bph = trig_pkg::BEEP_PHASES;
      next_btm = trig_pkg::BEEP_CYC;
    end else if (bph != 3'h0) begin
      if (btm == 8'h00) begin
        next_bph = bph - 3'h1;
        next_btm = trig_pkg::BEEP_CYC;
      end else begin
        next_btm = btm - 8'h01;
      end
    end
    next_beep = next_bph[0];
  end

  // Read data stand for exactly the cycle after the strobe.
  always_comb begin
    next_rdata = 32'h0000_0000;
    if (i_rd) begin
      if (i_addr == trig_pkg::A_STATUS) begin
        next_rdata[trig_pkg::ST_STATE +: 2] = st;
        next_rdata[trig_pkg::ST_LEVEL +: 2] = o_level;
        next_rdata[trig_pkg::ST_TOTAL +: 6] = total;
        next_rdata[trig_pkg::ST_USER] = use_user;
        next_rdata[trig_pkg::ST_DONE] = o_done;
        next_rdata[trig_pkg::ST_NLEV +: 3] = nlev;
      end else if (i_addr == trig_pkg::A_DELAY) begin
        next_rdata[15:0] = delay;
      end else if (i_addr == trig_pkg::A_CTRL) begin
        next_rdata[1:0] = width;
      end
    end
  end

  always_ff @(posedge i_mclk or negedge i_resetn) begin
    if (!i_resetn) begin
      st <= trig_pkg::S_IDLE;
      o_level <= 2'h0;
      rep <= 4'h0;
      o_store <= 1'b0;
      o_trigger <= 1'b0;
      o_done <= 1'b0;
      bph <= 3'h0;
      btm <= 8'h00;
      o_beep <= 1'b0;
      o_rdata <= 32'h0000_0000;
    end else begin
      st <= next_st;
      o_level <= next_level;
      rep <= next_rep;
      o_store <= next_store;
      o_trigger <= next_trigger;
      o_done <= next_done;
      bph <= next_bph;
      btm <= next_btm;
      o_beep <= next_beep;
      o_rdata <= next_rdata;
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge i_mclk);
  endclocking
  default disable iff (!i_resetn);

  // External clocks of a flush begun by stop; three from reset, and it rests at two after that flush.
  logic [1:0] stop_ticks, next_stop_ticks;
  always_comb begin
    next_stop_ticks = stop_ticks;
    if (stop_cmd && o_store) begin
      next_stop_ticks = 2'h0;
    end else if (st == trig_pkg::S_FLUSH && i_sample_en && stop_ticks != 2'h3) begin
      next_stop_ticks = stop_ticks + 2'h1;
    end
  end

  always_ff @(posedge i_mclk or negedge i_resetn) begin
    if (!i_resetn) begin
      stop_ticks <= 2'h3;
    end else begin
      stop_ticks <= next_stop_ticks;
    end
  end

  sequence s_flush_entry;
    st == trig_pkg::S_FLUSH && !o_store;
  endsequence

  property p_restart;
    (st == trig_pkg::S_SEARCH && !stop_cmd && q && w_hit) |=> (o_level == 2'h0 && rep == 4'h0);
  endproperty
  a_restart: assert property (p_restart) else $error("without did not restart"); // RULE4

  property p_hold;
    (st == trig_pkg::S_SEARCH && !stop_cmd && !q) |=> $stable(o_level) && $stable(rep);
  endproperty
  a_hold: assert property (p_hold) else $error("level moved without a clock"); // RULE2

  property p_repeat;
    (st == trig_pkg::S_SEARCH && !stop_cmd && q && m_hit && !w_hit && !rep_met)
      |=> $stable(o_level) && rep == $past(rep) + 4'h1;
  endproperty
  a_repeat: assert property (p_repeat) else $error("advanced before count met"); // RULE3

  property p_zero;
    (fire && !stop_cmd && delay == 16'h0000) |=> o_trigger && !o_store && st == trig_pkg::S_FLUSH;
  endproperty
  a_zero: assert property (p_zero) else $error("zero delay kept storing"); // RULE20

  property p_qual;
    (st == trig_pkg::S_DELAY && !q && !stop_cmd) |=> st == trig_pkg::S_DELAY;
  endproperty
  a_qual: assert property (p_qual) else $error("delay ended on unqualified clock"); // RULE15

  property p_stop;
    (stop_cmd && st == trig_pkg::S_SEARCH) |=> s_flush_entry;
  endproperty
  a_stop: assert property (p_stop) else $error("stop kept storing"); // RULE17

  property p_stop_done;
    (st == trig_pkg::S_FLUSH && i_sample_en && stop_ticks == 2'h1)
      |=> o_done && st == trig_pkg::S_IDLE;
  endproperty
  a_stop_done: assert property (p_stop_done) else $error("stop flush not two clocks"); // RULE17

  property p_clamp;
    (i_wr && i_addr == trig_pkg::A_COUNT && i_wdata[6:0] > trig_pkg::CNT_MAX)
      |=> cnt[$past(cl)] == trig_pkg::CNT_MAX;
  endproperty
  a_clamp: assert property (p_clamp) else $error("count not clamped"); // RULE6

  property p_refuse;
    refuse |=> $stable(use_user) ##16 o_beep ##16 !o_beep;
  endproperty
  a_refuse: assert property (p_refuse) else $error("oversize total accepted"); // RULE7

  property p_predef;
    (cmd_wr && i_wdata[trig_pkg::C_PREDEF]) |=> !use_user && !use_eff;
  endproperty
  a_predef: assert property (p_predef) else $error("default sequence not restored"); // RULE12

  property p_quant;
    (i_wr && i_addr == trig_pkg::A_DELAY) |=> trig_pkg::quant(delay, width) == delay;
  endproperty
  a_quant: assert property (p_quant) else $error("delay not quantised"); // RULE19

  property p_clear;
    (i_wr && i_addr == trig_pkg::A_KEY && i_wdata[trig_pkg::K_ACT +: 2] == trig_pkg::ACT_CLEAR)
      |=> wst[$past(kl)][$past(i_wdata[trig_pkg::K_FIELD])] == 8'h00;
  endproperty
  a_clear: assert property (p_clear) else $error("cleared field kept words"); // RULE10

endmodule

/* sut_model.sv */
// Behavioural model of the probed system that supplies samples.
`timescale 1ns/1ps
module sut_model (
  input wire logic i_mclk,
  input wire logic i_resetn,
  input wire logic i_run,
  input wire logic i_slow,
  input wire logic [3:0] i_hit,
  input wire logic i_qual,
  output logic o_sample_en,
  output logic o_data_qual,
  output logic [3:0] o_word_hit
);
  logic [1:0] phase;
  // Free phase counter; slow mode samples only once every four cycles.
  always_ff @(posedge i_mclk or negedge i_resetn) begin
    if (!i_resetn) begin
      phase <= 2'h0;
    end else begin
      phase <= phase + 2'h1;
    end
  end
  assign o_sample_en = i_run && (!i_slow || phase == 2'h0);
  // Off-sample lines carry the inverse, so stale values never look valid.
  assign o_word_hit = o_sample_en ? i_hit : ~i_hit;
  assign o_data_qual = o_sample_en ? i_qual : ~i_qual;
endmodule

/* testbench.sv */
// Self-checking bench for the trigger sequencer.
`timescale 1ns/1ps
module testbench;
  logic i_mclk = 1'b0, i_resetn = 1'b0, i_wr = 1'b0, i_rd = 1'b0;
  logic [7:0] i_addr = 8'h00;
  logic [31:0] i_wdata = 32'h0, o_rdata, d;
  logic run = 1'b0, slow = 1'b0, qual = 1'b1;
  logic [3:0] hit = 4'h0, word_hit;
  logic sample_en, data_qual, o_store, o_trigger, o_done, o_beep;
  logic [1:0] o_level;
  int n_mismatch = 0;
  int checks_done = 0;
  always #12.5 i_mclk = ~i_mclk;
  trig_sequencer u_dut (.i_mclk(i_mclk), .i_resetn(i_resetn), .i_addr(i_addr),
    .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
    .i_sample_en(sample_en), .i_data_qual(data_qual), .i_word_hit(word_hit),
    .o_store(o_store), .o_trigger(o_trigger), .o_done(o_done), .o_beep(o_beep),
    .o_level(o_level));
  sut_model u_sut (.i_mclk(i_mclk), .i_resetn(i_resetn), .i_run(run), .i_slow(slow),
    .i_hit(hit), .i_qual(qual), .o_sample_en(sample_en), .o_data_qual(data_qual),
    .o_word_hit(word_hit));
  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic finish_test();
    $display("mismatches %0d checks %0d", n_mismatch, checks_done);
    if (n_mismatch == 0 && checks_done > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  task automatic chk(input string name, input logic [31:0] e, input logic [31:0] g);
    checks_done++;
    if (g !== e) begin
      n_mismatch++;
      $display("wrong value %s expected %0h seen %0h", name, e, g);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge i_mclk);
    i_wr <= 1'b1;
    i_addr <= a;
    i_wdata <= v;
    @(posedge i_mclk);
    i_wr <= 1'b0;
  endtask
  // Read data stand only in the cycle after the strobe, so sample mid-cycle.
  task automatic rd(input logic [7:0] a);
    @(posedge i_mclk);
    i_rd <= 1'b1;
    i_addr <= a;
    @(posedge i_mclk);
    i_rd <= 1'b0;
    @(negedge i_mclk);
    d = o_rdata;
  endtask
  // Hand exactly n samples to the block; a stuck model ends the run.
  task automatic feed(input logic [3:0] h, input logic q, input int n);
    int k;
    k = 0;
    @(posedge i_mclk);
    hit <= h;
    qual <= q;
    run <= 1'b1;
    for (int t = 0; t < 200 && k < n; t++) begin
      @(negedge i_mclk);
      if (sample_en === 1'b1) k++;
    end
    @(posedge i_mclk);
    run <= 1'b0;
    if (k < n) begin
      n_mismatch++;
      finish_test();
    end
    @(negedge i_mclk);
  endtask
  // Look for the one-cycle trigger pulse within four falling edges; o_store is not checked.
  task automatic wtrig();
    logic seen;
    seen = 1'b0;
    for (int t = 0; t < 4 && !seen; t++) begin
      if (o_trigger === 1'b1) seen = 1'b1;
      if (!seen) @(negedge i_mclk);
    end
    chk("trigger", 1, seen);
  endtask
  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_reset();
    rd(trig_pkg::A_STATUS);
    chk("status", 32'h1010, d);
    rd(trig_pkg::A_CTRL);
    chk("width", 32'h3, d);
    rd(8'hFC);
    chk("unmapped", 32'h0, d);
  endtask
  task automatic t_default();
    wr(trig_pkg::A_CMD, 32'h1);
    feed(4'hE, 1'b1, 3);
    chk("store", 1, o_store);
    feed(4'h1, 1'b1, 1);
    chk("store", 0, o_store);
    slow <= 1'b1;
    feed(4'h0, 1'b1, 16);
    chk("done", 0, o_done);
    feed(4'h0, 1'b1, 1);
    chk("done", 1, o_done);
    slow <= 1'b0;
  endtask
  task automatic t_delay();
    logic [31:0] q [4] = '{32'h50, 32'h50, 32'h5A, 32'h5F};
    for (int w = 0; w < 4; w++) begin
      wr(trig_pkg::A_CTRL, w);
      wr(trig_pkg::A_DELAY, 32'h63);
      rd(trig_pkg::A_DELAY);
      chk("delay", q[w], d);
    end
    wr(trig_pkg::A_START, 32'h10064);
    rd(trig_pkg::A_DELAY);
    chk("delay", 32'h37F, d);
    wr(trig_pkg::A_DELAY, 32'hA);
    wr(trig_pkg::A_CMD, 32'h1);
    wtrig_feed();
    feed(4'h0, 1'b0, 3);
    feed(4'h0, 1'b1, 9);
    chk("store", 1, o_store);
    feed(4'h0, 1'b1, 1);
    chk("store", 0, o_store);
    feed(4'h0, 1'b1, 17);
    chk("done", 1, o_done);
  endtask
  task automatic wtrig_feed();
    feed(4'h1, 1'b1, 1);
    wtrig();
  endtask
  task automatic t_stop();
    wr(trig_pkg::A_CMD, 32'h1);
    wr(trig_pkg::A_CMD, 32'h2);
    repeat (2) @(negedge i_mclk);
    chk("store", 0, o_store);
    feed(4'h0, 1'b1, 1);
    chk("done", 0, o_done);
    feed(4'h0, 1'b1, 1);
    chk("done", 1, o_done);
  endtask
  task automatic t_user();
    int beeps;
    logic prev;
    beeps = 0;
    prev = 1'b0;
    wr(trig_pkg::A_DELAY, 32'h0);
    wr(trig_pkg::A_CMD, 32'h4);
    wr(trig_pkg::A_COUNT, 32'h2);
    wr(trig_pkg::A_COUNT, 32'h114);
    rd(trig_pkg::A_STATUS);
    chk("total", 32'hF, {26'h0, d[9:4]});
    wr(trig_pkg::A_CMD, 32'h10);
    for (int t = 0; t < 150; t++) begin
      @(negedge i_mclk);
      if (o_beep === 1'b1 && !prev) beeps++;
      prev = (o_beep === 1'b1);
    end
    chk("beeps", 3, beeps);
    rd(trig_pkg::A_STATUS);
    chk("user", 0, d[10]);
    wr(trig_pkg::A_COUNT, 32'h101);
    wr(trig_pkg::A_KEY, 32'h0);
    wr(trig_pkg::A_KEY, 32'h9);
    wr(trig_pkg::A_KEY, 32'hE);
    for (int i = 0; i < 3; i++) wr(trig_pkg::A_KEY, 32'hB);
    wr(trig_pkg::A_CMD, 32'h10);
    rd(trig_pkg::A_STATUS);
    chk("user", 1, d[10]);
    wr(trig_pkg::A_CMD, 32'h1);
    feed(4'h1, 1'b1, 1);
    chk("level", 0, o_level);
    feed(4'h1, 1'b1, 1);
    chk("level", 1, o_level);
    feed(4'h0, 1'b1, 1);
    chk("level", 1, o_level);
    feed(4'h6, 1'b1, 1);
    chk("level", 0, o_level);
    feed(4'h1, 1'b1, 2);
    feed(4'h2, 1'b1, 1);
    wtrig();
    feed(4'h0, 1'b1, 17);
    wr(trig_pkg::A_CMD, 32'h20);
    rd(trig_pkg::A_STATUS);
    chk("user", 0, d[10]);
    wr(trig_pkg::A_COUNT, 32'h1);
    wr(trig_pkg::A_KEY, 32'h40);
    wr(trig_pkg::A_CMD, 32'h18);
    wr(trig_pkg::A_CMD, 32'h1);
    feed(4'hF, 1'b1, 3);
    chk("store", 1, o_store);
  endtask
  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (20) @(posedge i_mclk);
    i_resetn <= 1'b1;
    t_reset();
    t_default();
    t_delay();
    t_stop();
    t_user();
    finish_test();
  end
endmodule
